/* cssqt_map.svh */
// constants for the charge sequencer and safety timer block
// assumes a 125 MHz clock; analog comparators arrive as async levels
// Notes on behaviour
// (RQ1) one of charge, boost or hi-z mode
// (RQ2) hi-z mode: no charge, no boost
// (RQ3) charge mode enables all four regulation loops
// (RQ4) below short threshold: short-circuit current only
// (RQ5) above short: ramp current, input cap 100 mA
// (RQ6) regulation voltage host-set, 3.5 to 4.44 V
// (RQ7) terminate at termination current above recharge level
// (RQ8) termination disabled while enable bit is 0
// (RQ9) restart on recharge, weak POR, enable toggle, reset
// (RQ10) charge start runs long timer; host write stops it
// (RQ11) stopped long timer starts short host timer
// (RQ12) kick restarts short timer, kick self-clears
// (RQ13) short expiry: terminate, defaults, long timer, resume
// (RQ14) short mode with host, long mode without
// (RQ15) long expiry: charger off, fault code reported
// (RQ16) fault cleared by POR; status held until read
// (RQ17) converter at fixed 3 MHz, duty 0 to 99.5%
// (RQ18) cycle ends early at high-side peak limit
// (RQ19) low side off before reversal, sync above 100mA
// (RQ20) blocking switch off when bus below battery node
// (RQ21) thermal shutdown stops switching, freezes timers
// (RQ22) weak no-host power-up: cap from otg pin
// (RQ23) host kicks well inside short timer period
`ifndef CSSQT_MAP_SVH
`define CSSQT_MAP_SVH
`define CSSQT_CLK_MHZ        125
`define CSSQT_LONG_SEC       1920
`define CSSQT_SHORT_SEC      32
`define CSSQT_TICK_CYCLES    (`CSSQT_CLK_MHZ * 1000)
`define CSSQT_TICKS_PER_SEC  1000
`define CSSQT_SW_NS          333
`define CSSQT_SW_CYCLES      ((`CSSQT_SW_NS * `CSSQT_CLK_MHZ) / 1000)
`define CSSQT_DUTY_MAX       8'hc7
`define CSSQT_VREG_MIN       6'h00
`define CSSQT_VREG_MAX       6'h2f
`define CSSQT_VREG_RST       6'h02
`define CSSQT_TERMINATION_CURRENT_RST      3'h0
`define CSSQT_ICHG_RST       4'h0
`define CSSQT_STAT_READY     2'h0
`define CSSQT_STAT_CHARGING  2'h1
`define CSSQT_STAT_DONE      2'h2
`define CSSQT_STAT_FAULT     2'h3
`define CSSQT_FAULT_NONE     3'h0
`define CSSQT_FAULT_TIMER    3'h6
`endif

/* cssqt_pkg.sv */
// types shared by the charge sequencer and safety timer
// assumes cssqt_map.svh holds all numeric constants
package cssqt_pkg;
   typedef enum logic [5:0] {
      CS_HIZ   = 6'b000001,
      CS_SHORT = 6'b000010,
      CS_FAST  = 6'b000100,
      CS_DONE  = 6'b001000,
      CS_FAULT = 6'b010000,
      CS_BOOST = 6'b100000
   } cssqt_state_type;
   // analog comparator levels, all asynchronous to clk
   typedef struct packed {
      logic bus_above_batt;
      logic batt_below_short;
      logic batt_below_vreg;
      logic batt_below_recharge;
      logic batt_below_weak;
      logic at_term_current;
      logic hs_peak_limit;
      logic ls_above_sync;
      logic thermal_shutdown;
      logic otg_pin;
   } cssqt_sense_type;
   // host register fields as decoded by the serial slave
   typedef struct packed {
      logic       charge_enable;
      logic       hiz_request;
      logic       boost_request;
      logic       term_enable;
      logic       reg_reset;
      logic       cap_500;
      logic [5:0] vreg_code;
      logic [2:0] termination_current_code;
      logic [3:0] ichg_code;
   } cssqt_cfg_type;
   typedef struct packed {
      logic       charge_loops_en;
      logic       short_current;
      logic       ramp_en;
      logic       cap_500;
      logic [5:0] vreg_code;
      logic [2:0] termination_current_code;
      logic [3:0] ichg_code;
   } cssqt_loop_type;
   typedef struct packed {
      logic       rev_block_on;
      logic       high_side_on;
      logic       low_side_on;
      logic       boost_on;
   } cssqt_gate_type;
endpackage

/* cssqt_top.sv */
// charge mode sequencer, safety timers and switch gating
// assumes a serial slave supplies decoded host writes on clk; sense levels are async
`timescale 1ns/1ps
`include "cssqt_map.svh"
module cssqt_top (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire cssqt_pkg::cssqt_sense_type sense_in,
   input  wire cssqt_pkg::cssqt_cfg_type   cfg_in,
   input  wire logic                      host_write,
   input  wire logic                      safety_timer_kick,
   input  wire logic                      status_read,
   input  wire logic [7:0]                duty_cmd,
   input  wire logic                      auto_charge_variant,
   output cssqt_pkg::cssqt_loop_type      loop_out,
   output cssqt_pkg::cssqt_gate_type      gate_out,
   output logic [1:0]                     status_state_field,
   output logic [2:0]                     fault_code,
   output logic                           short_timer_mode,
   output logic                           kick_pending,
   output logic                           defaults_request
);
   import cssqt_pkg::*;

   // saturate the host's regulation voltage code to the legal window
   // codes above the top would ask for more than the cell can take;
   // clamping keeps a stray host write harmless
   function automatic logic [5:0] clamp_vreg(input logic [5:0] c);
      clamp_vreg = (c > `CSSQT_VREG_MAX) ? `CSSQT_VREG_MAX : c;
   endfunction

   // a charge always opens in the phase the cell voltage calls for
   function automatic cssqt_state_type entry_state(input logic below_short);
      entry_state = below_short ? CS_SHORT : CS_FAST;
   endfunction

   // frame position scaled to half-percent steps; worked at 16 bits
   // because 40 x 200 does not fit in a byte
   function automatic logic [15:0] frame_share(input logic [5:0] pos);
      frame_share = (16'(pos) * 16'd200) / 16'(`CSSQT_SW_CYCLES);
   endfunction

   // two-flop synchroniser for the analog levels
   // the first flop may go metastable, so only s_q feeds
   // the logic below
   cssqt_sense_type s_meta_q, s_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_meta_q <= '0;
         s_q      <= '0;
      end else begin
         s_meta_q <= sense_in;
         s_q      <= s_meta_q;
      end
   end

   // one-second tick prescaler, frozen in thermal shutdown
   // two stages keep each counter narrow: 125000 cycles make a
   // millisecond, a thousand of those the second both timers count.
   // limitation: a timer restart does not realign the prescaler, so
   // the first second after a restart may come early
   logic [16:0] pre_q, pre_d;
   logic [9:0]  ms_q, ms_d;
   logic        sec_tick;
   always_comb begin
      pre_d    = pre_q;
      ms_d     = ms_q;
      sec_tick = 1'b0;
      if (!s_q.thermal_shutdown) begin // RQ21
         if (pre_q == 17'(`CSSQT_TICK_CYCLES - 1)) begin
            pre_d = '0;
            if (ms_q == 10'(`CSSQT_TICKS_PER_SEC - 1)) begin
               ms_d     = '0;
               sec_tick = 1'b1;
            end else begin
               ms_d = ms_q + 10'h001;
            end
         end else begin
            pre_d = pre_q + 17'h00001;
         end
      end
   end
   // prescaler registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_q <= '0;
         ms_q  <= '0;
      end else begin
         pre_q <= pre_d;
         ms_q  <= ms_d;
      end
   end

   // charge state machine and safety timers
   // one counter serves both timers: short_mode_q picks the limit,
   // so a hand-over only clears it and flips the mode bit.
   // por_q counts down from reset so the weak-battery check reads
   // the comparators once the synchroniser holds a real sample,
   // not the reset value of its flops
   cssqt_state_type st_q, st_d;
   logic [10:0] tmr_q, tmr_d;
   logic        short_mode_q, short_mode_d;
   logic        kick_q, kick_d;
   logic        ce_q, ce_d;
   logic        dflt_q, dflt_d;
   logic        cap_otg_q, cap_otg_d;
   logic [1:0]  por_q, por_d;
   logic        restart;
   logic        long_exp, short_exp;
   always_comb begin
      st_d         = st_q;
      tmr_d        = tmr_q;
      short_mode_d = short_mode_q;
      kick_d       = kick_q;
      ce_d         = cfg_in.charge_enable;
      dflt_d       = 1'b0;
      cap_otg_d    = cap_otg_q;
      por_d        = (por_q == 2'h0) ? 2'h0 : por_q - 2'h1;
      long_exp     = !short_mode_q && (tmr_q == 11'(`CSSQT_LONG_SEC));
      short_exp    = short_mode_q && (tmr_q == 11'(`CSSQT_SHORT_SEC));
      // restart sources: recharge, weak-battery power-up, enable toggle, reset
      // reg_reset is a level and keeps restarting while it is held
      restart = (st_q == CS_DONE && s_q.batt_below_recharge)                     // RQ9
              || (por_q == 2'h1 && auto_charge_variant && s_q.batt_below_weak)   // RQ9
              || (ce_q != cfg_in.charge_enable)                                  // RQ9
              || cfg_in.reg_reset;                                               // RQ9
      // the otg pin sets the cap only for a weak cell with no host yet;
      // the first host write hands the cap back to the register field
      if (por_q == 2'h1) begin
         cap_otg_d = auto_charge_variant && s_q.batt_below_weak && s_q.otg_pin; // RQ22
      end
      if (host_write) begin
         cap_otg_d = 1'b0;
      end
      // timer counts seconds; thermal freeze lives in the tick
      if (st_q != CS_HIZ && st_q != CS_FAULT && st_q != CS_BOOST && sec_tick) begin
         tmr_d = tmr_q + 11'h001;
      end
      // any host write stops the long timer and starts supervision
      if (host_write && !short_mode_q) begin
         short_mode_d = 1'b1; // RQ10 RQ11 RQ14
         tmr_d        = '0;
      end
      // kick latches, restarts short timer, then clears itself
      // held one cycle so the bit reads back as 1 once before it
      // drops; a kick in long mode only sets and clears the bit
      if (safety_timer_kick) begin
         kick_d = 1'b1;
      end else if (kick_q) begin
         kick_d = 1'b0; // RQ12
         if (short_mode_q) begin
            tmr_d = '0; // RQ12
         end
      end
      // mode decode: hi-z is home; boost starts only from it, charging from it or from done
      unique case (st_q)
         CS_HIZ: begin
            // a charge opens on a restart event or a cell below regulation,
            // which also covers a cell fitted while the bus is up
            if (cfg_in.boost_request && !cfg_in.hiz_request) begin
               st_d = CS_BOOST; // RQ1
            end else if (!cfg_in.hiz_request && cfg_in.charge_enable &&
                         (restart || s_q.batt_below_vreg)) begin
               st_d  = entry_state(s_q.batt_below_short);
               tmr_d = '0; // RQ10
            end
         end
         CS_BOOST: begin
            // thermal shutdown only gates the switch; the mode stays
            if (!cfg_in.boost_request || cfg_in.hiz_request) begin
               st_d = CS_HIZ;
            end
         end
         CS_SHORT, CS_FAST: begin
            // expiry is judged only while charging: an idle cell draws
            // no current and needs no backstop
            if (cfg_in.hiz_request || !cfg_in.charge_enable) begin
               st_d = CS_HIZ; // RQ2
            end else if (long_exp) begin
               st_d = CS_FAULT; // RQ15
            end else if (short_exp) begin
               dflt_d       = 1'b1; // RQ13
               short_mode_d = 1'b0; // RQ13 RQ14
               tmr_d        = '0;
               st_d         = entry_state(s_q.batt_below_short);
            end else if (st_q == CS_SHORT) begin
               if (!s_q.batt_below_short) begin
                  st_d = CS_FAST; // RQ4
               end
            end else if (s_q.batt_below_short) begin
               st_d = CS_SHORT; // RQ4
            end else if (!s_q.batt_below_vreg && !s_q.batt_below_recharge &&
                         s_q.at_term_current && cfg_in.term_enable) begin
               st_d = CS_DONE; // RQ7 RQ8
            end
         end
         CS_DONE: begin
            // a full cell waits for the recharge level or a host restart;
            // hi-z still wins so the host can park the charger
            if (cfg_in.hiz_request) begin
               st_d = CS_HIZ;
            end else if (restart) begin
               st_d  = entry_state(s_q.batt_below_short);
               tmr_d = '0;
            end
         end
         CS_FAULT: begin
            // only a power-on reset leaves the fault; no write clears it
            st_d = CS_FAULT; // RQ16
         end
      endcase
   end
   // reset: hi-z, long-timer mode, fault and timers cleared
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q         <= CS_HIZ;
         tmr_q        <= '0;
         short_mode_q <= 1'b0;
         kick_q       <= 1'b0;
         ce_q         <= 1'b0;
         dflt_q       <= 1'b0;
         cap_otg_q    <= 1'b0;
         por_q        <= 2'h3; // reset stands in for bus power-on
      end else begin
         st_q         <= st_d;
         tmr_q        <= tmr_d;
         short_mode_q <= short_mode_d;
         kick_q       <= kick_d;
         ce_q         <= ce_d;
         dflt_q       <= dflt_d;
         cap_otg_q    <= cap_otg_d;
         por_q        <= por_d;
      end
   end

   // status field freezes after a fault until the host reads it
   // the code only takes the timer value here; other faults belong
   // to protection logic outside this block. a read while the fault
   // persists re-latches it on the next cycle
   logic [1:0] stat_q, stat_d;
   logic [2:0] fcode_q, fcode_d;
   logic       held_q, held_d;
   logic [1:0] stat_now;
   always_comb begin
      unique case (st_q)
         CS_SHORT, CS_FAST: stat_now = `CSSQT_STAT_CHARGING;
         CS_DONE:           stat_now = `CSSQT_STAT_DONE;
         CS_FAULT:          stat_now = `CSSQT_STAT_FAULT;
         default:           stat_now = `CSSQT_STAT_READY;
      endcase
      stat_d  = stat_q;
      fcode_d = fcode_q;
      held_d  = held_q;
      if (!held_q) begin
         stat_d = stat_now;
         if (st_q == CS_FAULT) begin
            fcode_d = `CSSQT_FAULT_TIMER; // RQ15
            held_d  = 1'b1; // RQ16
         end
      end else if (status_read) begin
         held_d = 1'b0; // RQ16
      end
   end
   // status registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat_q  <= `CSSQT_STAT_READY;
         fcode_q <= `CSSQT_FAULT_NONE;
         held_q  <= 1'b0;
      end else begin
         stat_q  <= stat_d;
         fcode_q <= fcode_d;
         held_q  <= held_d;
      end
   end

   // 3 MHz switching frame with duty compare and peak cutoff
   // the frame counter runs freely, so a new charge joins the frame
   // at whatever position it has reached. the peak cutoff holds to the end of
   // the frame so a current spike cannot turn the high side back on
   // within the same switching cycle
   logic [5:0] sw_q, sw_d;
   logic       cut_q, cut_d;
   logic [7:0] duty;
   logic       charging;
   cssqt_gate_type gate_d, gate_q;
   cssqt_loop_type loop_d, loop_q;
   always_comb begin
      charging = (st_q == CS_SHORT || st_q == CS_FAST);
      duty     = (duty_cmd > `CSSQT_DUTY_MAX) ? `CSSQT_DUTY_MAX : duty_cmd; // RQ17
      sw_d     = (sw_q == 6'(`CSSQT_SW_CYCLES - 1)) ? 6'h00 : sw_q + 6'h01; // RQ17
      cut_d    = cut_q;
      if (sw_d == 6'h00) begin
         cut_d = 1'b0;
      end else if (s_q.hs_peak_limit) begin
         cut_d = 1'b1; // RQ18
      end
      // the blocking switch follows the bus comparator so the cell can
      // never feed the bus, whatever the converter does
      gate_d.rev_block_on = charging && s_q.bus_above_batt; // RQ20
      // high side on for the first duty share of the frame, minus a peak cutoff
      gate_d.high_side_on = charging && st_q == CS_FAST && !s_q.thermal_shutdown && !cut_d
                            && s_q.bus_above_batt
                            && (frame_share(sw_q) < 16'(duty)); // RQ17 RQ18
      gate_d.low_side_on  = charging && st_q == CS_FAST && !s_q.thermal_shutdown
                            && !gate_d.high_side_on && s_q.ls_above_sync; // RQ19 RQ21
      gate_d.boost_on     = (st_q == CS_BOOST) && !s_q.thermal_shutdown; // RQ1 RQ21
      loop_d.charge_loops_en = charging; // RQ3
      loop_d.short_current   = (st_q == CS_SHORT); // RQ4
      loop_d.ramp_en         = (st_q == CS_FAST); // RQ5
      // long-timer mode runs on defaults: host parameters count only
      // while the host proves it is alive inside the short window
      loop_d.cap_500         = (dflt_q || !short_mode_q) ? cap_otg_q : cfg_in.cap_500; // RQ5 RQ22
      loop_d.vreg_code       = (dflt_q || !short_mode_q) ? `CSSQT_VREG_RST
                                                        : clamp_vreg(cfg_in.vreg_code); // RQ6
      loop_d.termination_current_code      = short_mode_q ? cfg_in.termination_current_code : `CSSQT_TERMINATION_CURRENT_RST;
      loop_d.ichg_code       = short_mode_q ? cfg_in.ichg_code : `CSSQT_ICHG_RST; // RQ13
   end
   // frame, cutoff and output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sw_q   <= '0;
         cut_q  <= 1'b0;
         gate_q <= '0;
         loop_q <= '0;
      end else begin
         sw_q   <= sw_d;
         cut_q  <= cut_d;
         gate_q <= gate_d;
         loop_q <= loop_d;
      end
   end

   // outputs straight from flops
   // so the gate drivers never see a glitch from the decode above
   assign gate_out           = gate_q;
   assign loop_out           = loop_q;
   assign status_state_field = stat_q;
   assign fault_code         = fcode_q;
   assign short_timer_mode   = short_mode_q;
   assign kick_pending       = kick_q;
   assign defaults_request   = dflt_q;
endmodule

/* cssqt_checker.sv */
// checker for the charge sequencer and safety timer top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module cssqt_checker (
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire cssqt_pkg::cssqt_sense_type sense_in,
   input wire cssqt_pkg::cssqt_cfg_type   cfg_in,
   input wire logic                       host_write,
   input wire logic                       safety_timer_kick,
   input wire cssqt_pkg::cssqt_loop_type  loop_out,
   input wire cssqt_pkg::cssqt_gate_type  gate_out,
   input wire logic [2:0]                 fault_code,
   input wire logic                       short_timer_mode,
   input wire logic                       kick_pending,
   input wire logic                       defaults_request
);
   import cssqt_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // repetition counts allow for the two-flop sense synchroniser
   property p_mode_excl; !(gate_out.boost_on && loop_out.charge_loops_en); endproperty
   a_mode_excl: assert property (p_mode_excl) else $error("boost and charge together");
   property p_hiz;
      cfg_in.hiz_request [*5] |-> !gate_out.high_side_on && !loop_out.charge_loops_en;
   endproperty
   a_hiz: assert property (p_hiz) else $error("switching in hi-z mode");
   property p_short; loop_out.short_current |-> !loop_out.ramp_en; endproperty
   a_short: assert property (p_short) else $error("ramp during short current");
   property p_vreg; loop_out.vreg_code <= 6'h2f; endproperty
   a_vreg: assert property (p_vreg) else $error("regulation code out of range");
   property p_take; $rose(short_timer_mode) |-> $past(host_write); endproperty
   a_take: assert property (p_take) else $error("short mode without host write");
   property p_enter; host_write && !short_timer_mode |=> short_timer_mode; endproperty
   a_enter: assert property (p_enter) else $error("host write kept long mode");
   property p_kick; safety_timer_kick && short_timer_mode |=> kick_pending; endproperty
   a_kick: assert property (p_kick) else $error("kick not taken");
   property p_kick_clr; kick_pending && !safety_timer_kick |=> !kick_pending; endproperty
   a_kick_clr: assert property (p_kick_clr) else $error("kick bit stuck");
   property p_drop;
      $fell(short_timer_mode) |-> defaults_request || $past(defaults_request);
   endproperty
   a_drop: assert property (p_drop) else $error("short mode left without expiry");
   property p_fault_hold; fault_code == 3'h6 |=> fault_code == 3'h6; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("timer fault cleared");
   property p_block; !sense_in.bus_above_batt [*5] |-> !gate_out.rev_block_on; endproperty
   a_block: assert property (p_block) else $error("blocking switch on");
   property p_therm;
      sense_in.thermal_shutdown [*5] |-> !gate_out.high_side_on && !gate_out.low_side_on;
   endproperty
   a_therm: assert property (p_therm) else $error("switching in shutdown");
   c_take: cover property ($rose(short_timer_mode));
   c_kick: cover property (kick_pending);
   c_hiz: cover property (cfg_in.hiz_request [*5]);
endmodule

/* cssqt_host_model.sv */
// host processor model: decoded register writes, timer kicks, status reads
// assumes the block samples every rising edge; strobes change 1 ns after it
`timescale 1ns/1ps
module cssqt_host_model (
   input  wire logic                clk,
   output cssqt_pkg::cssqt_cfg_type cfg_out,
   output logic                     wr_out,
   output logic                     kick_out,
   output logic                     rd_out
);
   import cssqt_pkg::*;
   // no request pending until the bench asks for one
   initial begin
      cfg_out = '0;
      wr_out = 1'b0;
      kick_out = 1'b0;
      rd_out = 1'b0;
   end
   // one write: fields stay as levels, strobe held for one sampling edge
   task automatic put_cfg(input cssqt_cfg_type c);
      cfg_out = c;
      wr_out = 1'b1;
      @(posedge clk);
      #1 wr_out = 1'b0;
   endtask
   // kick bit write; the bench spaces these well inside the short period
   task automatic put_kick();
      kick_out = 1'b1;
      @(posedge clk);
      #1 kick_out = 1'b0;
   endtask
   // status read releases the held status field; the fault code stays latched
   task automatic put_read();
      rd_out = 1'b1;
      @(posedge clk);
      #1 rd_out = 1'b0;
   endtask
endmodule

/* tb_top.sv */
// self-checking bench for the charge sequencer and safety timer
// assumes timers in seconds are out of reach; only mode entry, kicks, limits, termination and reset are run
`timescale 1ns/1ps
module tb_top;
   import cssqt_pkg::*;
   logic            clk;
   logic            sys_rst;
   logic            auto_v;
   logic [7:0]      duty;
   cssqt_sense_type sense;
   cssqt_cfg_type   cfg;
   logic            wr, kick, rd, kp, stm, dflt;
   cssqt_loop_type  lp;
   cssqt_gate_type  gt;
   logic [1:0]      st;
   logic [2:0]      fc;
   int              num_errors = 0;
   int              compares = 0;
   cssqt_host_model host (.clk(clk), .cfg_out(cfg), .wr_out(wr), .kick_out(kick), .rd_out(rd));
   cssqt_top uut (.clk(clk), .sys_rst(sys_rst), .sense_in(sense), .cfg_in(cfg),
      .host_write(wr), .safety_timer_kick(kick), .status_read(rd), .duty_cmd(duty),
      .auto_charge_variant(auto_v), .loop_out(lp), .gate_out(gt), .status_state_field(st),
      .fault_code(fc), .short_timer_mode(stm), .kick_pending(kp), .defaults_request(dflt));
   // free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic cssqt_cfg_type base();
      base = '0;
      base.charge_enable = 1'b1;
      base.vreg_code = 6'h10;
   endfunction
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // kick ignored in long mode, then a host write hands control over
   task automatic t_takeover();
      host.put_kick();
      tick(2);
      chk(stm, 8'h00);
      host.put_cfg(base());
      chk(stm, 8'h01);
      tick(8);
      chk(lp.charge_loops_en, 8'h01);
      chk(lp.ramp_en, 8'h01);
      chk(gt.boost_on, 8'h00);
      sense.batt_below_short = 1'b1;
      tick(8);
      chk(lp.short_current, 8'h01);
      sense.batt_below_short = 1'b0;
      host.put_kick();
      chk(kp, 8'h01);
      tick(1);
      chk(kp, 8'h00);
   endtask
   // clamp, hi-z and switch protections, each put back afterwards
   task automatic t_limits();
      cssqt_cfg_type c = base();
      c.vreg_code = 6'h3f;
      host.put_cfg(c);
      tick(4);
      chk(lp.vreg_code, 8'h2f);
      c = base();
      c.hiz_request = 1'b1;
      host.put_cfg(c);
      tick(8);
      chk({gt.high_side_on, gt.boost_on, lp.charge_loops_en}, 8'h00);
      host.put_cfg(base());
      sense.bus_above_batt = 1'b0;
      tick(8);
      chk(gt.rev_block_on, 8'h00);
      sense.bus_above_batt = 1'b1;
      sense.thermal_shutdown = 1'b1;
      tick(8);
      chk({gt.high_side_on, gt.low_side_on}, 8'h00);
      sense.thermal_shutdown = 1'b0;
      tick(8);
      chk(gt.rev_block_on, 8'h01);
      chk(gt.high_side_on, 8'h01);
      duty = 8'h00;
      tick(3);
      chk(gt.high_side_on, 8'h00);
      duty = 8'hff;
   endtask
   // termination only when enabled, then recharge restarts the cycle
   task automatic t_term();
      cssqt_cfg_type c = base();
      host.put_cfg(c);
      sense.batt_below_vreg = 1'b0;
      sense.batt_below_recharge = 1'b0;
      sense.at_term_current = 1'b1;
      tick(10);
      chk(st, 8'h01);
      c.term_enable = 1'b1;
      host.put_cfg(c);
      tick(10);
      chk(st, 8'h02);
      host.put_read();
      sense.batt_below_recharge = 1'b1;
      sense.batt_below_vreg = 1'b1;
      sense.at_term_current = 1'b0;
      tick(10);
      chk(st, 8'h01);
   endtask
   // mid-run reset with a weak cell: otg pin sets the cap until a host write
   task automatic t_reset();
      sense.batt_below_weak = 1'b1;
      sense.otg_pin = 1'b1;
      sys_rst = 1'b1;
      tick(4);
      chk({kp, stm, dflt, st, fc}, 8'h00);
      sys_rst = 1'b0;
      tick(8);
      chk(lp.cap_500, 8'h01);
      chk(stm, 8'h00);
      host.put_cfg(base());
      tick(2);
      chk({stm, lp.cap_500}, 8'h02);
   endtask
   // main sequence: reset held 20 cycles, outputs quiet during it
   initial begin
      sys_rst = 1'b1;
      auto_v = 1'b1;
      duty = 8'hff;
      sense = '0;
      sense.bus_above_batt = 1'b1;
      sense.batt_below_vreg = 1'b1;
      sense.batt_below_recharge = 1'b1;
      tick(19);
      chk({kp, stm, dflt, st, fc}, 8'h00);
      chk(gt, 8'h00);
      tick(1);
      sys_rst = 1'b0;
      t_takeover();
      t_limits();
      t_term();
      t_reset();
      give_verdict();
   end
   // watchdog: the whole run needs about 130 cycles
   initial begin
      #(4000 * 8);
      num_errors++;
      give_verdict();
   end
endmodule
bind cssqt_top cssqt_checker chk_i (.clk(clk), .sys_rst(sys_rst), .sense_in(sense_in),
   .cfg_in(cfg_in), .host_write(host_write), .safety_timer_kick(safety_timer_kick),
   .loop_out(loop_out), .gate_out(gate_out), .fault_code(fault_code),
   .short_timer_mode(short_timer_mode), .kick_pending(kick_pending),
   .defaults_request(defaults_request));
